// ### logic/jtag_instruction_decode.sv
// jtag test access port with 16-bit instruction register and six data registers
`timescale 1ns/10ps
module jtag_instruction_decode (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // test port pins
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  output logic tdo_o,
  output logic tdo_oe_o,
  // boundary cells
  input wire logic [133:0] bsr_capture_i,
  output logic [133:0] bsr_update_o,
  output logic extest_o,
  // flash side
  input wire logic [7:0] flash_status_i,
  input wire logic [7:0] flash_rdata_i,
  output jtag_instruction_decode_pkg::flash_req_t flash_req_o
);

  typedef jtag_instruction_decode_pkg::tap_state_t tap_state_t;
  typedef jtag_instruction_decode_pkg::dr_sel_t dr_sel_t;

  // pin synchronisers
  logic tck_meta_q, tck_sync_q, tck_prev_q;
  logic tms_meta_q, tms_sync_q, tdi_meta_q, tdi_sync_q;
  logic [133:0] bsr_meta_q, bsr_sync_q;
  logic tck_rise, tck_fall;

  // all pins pass two flops; the tck edge is found one flop later
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      tck_meta_q <= 1'b0;
      tck_sync_q <= 1'b0;
      tck_prev_q <= 1'b0;
      tms_meta_q <= 1'b1;
      tms_sync_q <= 1'b1;
      tdi_meta_q <= 1'b0;
      tdi_sync_q <= 1'b0;
      bsr_meta_q <= jtag_instruction_decode_pkg::BSR_RESET;
      bsr_sync_q <= jtag_instruction_decode_pkg::BSR_RESET;
    end else begin
      tck_meta_q <= tck_i;
      tck_sync_q <= tck_meta_q;
      tck_prev_q <= tck_sync_q;
      tms_meta_q <= tms_i;
      tms_sync_q <= tms_meta_q;
      tdi_meta_q <= tdi_i;
      tdi_sync_q <= tdi_meta_q;
      bsr_meta_q <= bsr_capture_i;
      bsr_sync_q <= bsr_meta_q;
    end
  end

  assign tck_rise = tck_sync_q & ~tck_prev_q;
  assign tck_fall = ~tck_sync_q & tck_prev_q;

  // tap and scan state
  tap_state_t state_q, state_d;
  logic [15:0] ir_shift_q, ir_shift_d, ir_q, ir_d;
  logic [133:0] dr_shift_q, dr_shift_d, bsr_upd_q, bsr_upd_d;
  jtag_instruction_decode_pkg::flash_req_t flash_q, flash_d;
  logic tdo_q, tdo_d, tdo_oe_q, tdo_oe_d, extest_q, extest_d;
  dr_sel_t sel;
  logic [7:0] dr_len;

  function automatic dr_sel_t decode(input logic [15:0] ir);
    unique case (ir)
      jtag_instruction_decode_pkg::IR_EXTEST: decode = jtag_instruction_decode_pkg::SEL_BOUNDARY;
      jtag_instruction_decode_pkg::IR_SAMPLE: decode = jtag_instruction_decode_pkg::SEL_BOUNDARY;
      jtag_instruction_decode_pkg::IR_IDCODE: decode = jtag_instruction_decode_pkg::SEL_IDCODE;
      jtag_instruction_decode_pkg::IR_FLASH_CTRL: decode = jtag_instruction_decode_pkg::SEL_FLASH_CTRL;
      jtag_instruction_decode_pkg::IR_FLASH_DATA: decode = jtag_instruction_decode_pkg::SEL_FLASH_DATA;
      jtag_instruction_decode_pkg::IR_FLASH_ADDR: decode = jtag_instruction_decode_pkg::SEL_FLASH_ADDR;
      default: decode = jtag_instruction_decode_pkg::SEL_BYPASS;
    endcase
  endfunction

  assign sel = decode(ir_q);

  always_comb begin
    unique case (sel)
      jtag_instruction_decode_pkg::SEL_BOUNDARY: dr_len = jtag_instruction_decode_pkg::LEN_BSR;
      jtag_instruction_decode_pkg::SEL_BYPASS: dr_len = jtag_instruction_decode_pkg::LEN_BYPASS;
      jtag_instruction_decode_pkg::SEL_IDCODE: dr_len = jtag_instruction_decode_pkg::LEN_IDCODE;
      jtag_instruction_decode_pkg::SEL_FLASH_CTRL: dr_len = jtag_instruction_decode_pkg::LEN_FLASH_CTRL;
      jtag_instruction_decode_pkg::SEL_FLASH_DATA: dr_len = jtag_instruction_decode_pkg::LEN_FLASH_DATA;
      jtag_instruction_decode_pkg::SEL_FLASH_ADDR: dr_len = jtag_instruction_decode_pkg::LEN_FLASH_ADDR;
      default: dr_len = jtag_instruction_decode_pkg::LEN_BYPASS;
    endcase
  end

  always_comb begin
    state_d = state_q;
    ir_shift_d = ir_shift_q;
    ir_d = ir_q;
    dr_shift_d = dr_shift_q;
    bsr_upd_d = bsr_upd_q;
    flash_d = flash_q;
    tdo_d = tdo_q;
    tdo_oe_d = tdo_oe_q;
    // strobes last one core cycle
    flash_d.write = 1'b0;
    flash_d.read = 1'b0;
    if (tck_rise) begin
      unique case (state_q)
        jtag_instruction_decode_pkg::TAP_RESET:
          state_d = tms_sync_q ? state_q : jtag_instruction_decode_pkg::TAP_IDLE;
        jtag_instruction_decode_pkg::TAP_IDLE:
          state_d = tms_sync_q ? jtag_instruction_decode_pkg::TAP_SELECT_DR : state_q;
        jtag_instruction_decode_pkg::TAP_SELECT_DR:
          state_d = tms_sync_q ? jtag_instruction_decode_pkg::TAP_SELECT_IR
                               : jtag_instruction_decode_pkg::TAP_CAPTURE_DR;
        jtag_instruction_decode_pkg::TAP_CAPTURE_DR, jtag_instruction_decode_pkg::TAP_EXIT2_DR:
          state_d = tms_sync_q ? jtag_instruction_decode_pkg::TAP_EXIT1_DR
                               : jtag_instruction_decode_pkg::TAP_SHIFT_DR;
        jtag_instruction_decode_pkg::TAP_SHIFT_DR:
          state_d = tms_sync_q ? jtag_instruction_decode_pkg::TAP_EXIT1_DR : state_q;
        jtag_instruction_decode_pkg::TAP_EXIT1_DR:
          state_d = tms_sync_q ? jtag_instruction_decode_pkg::TAP_UPDATE_DR
                               : jtag_instruction_decode_pkg::TAP_PAUSE_DR;
        jtag_instruction_decode_pkg::TAP_PAUSE_DR:
          state_d = tms_sync_q ? jtag_instruction_decode_pkg::TAP_EXIT2_DR : state_q;
        jtag_instruction_decode_pkg::TAP_UPDATE_DR, jtag_instruction_decode_pkg::TAP_UPDATE_IR:
          state_d = tms_sync_q ? jtag_instruction_decode_pkg::TAP_SELECT_DR
                               : jtag_instruction_decode_pkg::TAP_IDLE;
        jtag_instruction_decode_pkg::TAP_SELECT_IR:
          state_d = tms_sync_q ? jtag_instruction_decode_pkg::TAP_RESET
                               : jtag_instruction_decode_pkg::TAP_CAPTURE_IR;
        jtag_instruction_decode_pkg::TAP_CAPTURE_IR, jtag_instruction_decode_pkg::TAP_EXIT2_IR:
          state_d = tms_sync_q ? jtag_instruction_decode_pkg::TAP_EXIT1_IR
                               : jtag_instruction_decode_pkg::TAP_SHIFT_IR;
        jtag_instruction_decode_pkg::TAP_SHIFT_IR:
          state_d = tms_sync_q ? jtag_instruction_decode_pkg::TAP_EXIT1_IR : state_q;
        jtag_instruction_decode_pkg::TAP_EXIT1_IR:
          state_d = tms_sync_q ? jtag_instruction_decode_pkg::TAP_UPDATE_IR
                               : jtag_instruction_decode_pkg::TAP_PAUSE_IR;
        jtag_instruction_decode_pkg::TAP_PAUSE_IR:
          state_d = tms_sync_q ? jtag_instruction_decode_pkg::TAP_EXIT2_IR : state_q;
      endcase
      unique case (state_q)
        jtag_instruction_decode_pkg::TAP_CAPTURE_IR:
          ir_shift_d = jtag_instruction_decode_pkg::IR_CAPTURE;
        jtag_instruction_decode_pkg::TAP_SHIFT_IR:
          ir_shift_d = {tdi_sync_q, ir_shift_q[15:1]};
        jtag_instruction_decode_pkg::TAP_UPDATE_IR:
          ir_d = ir_shift_q;
        jtag_instruction_decode_pkg::TAP_CAPTURE_DR: begin
          dr_shift_d = '0;
          unique case (sel)
            jtag_instruction_decode_pkg::SEL_BOUNDARY: dr_shift_d = bsr_sync_q;
            jtag_instruction_decode_pkg::SEL_IDCODE:
              dr_shift_d[31:0] = jtag_instruction_decode_pkg::IDCODE_VALUE;
            jtag_instruction_decode_pkg::SEL_FLASH_CTRL: dr_shift_d[7:0] = flash_status_i;
            jtag_instruction_decode_pkg::SEL_FLASH_DATA: begin
              dr_shift_d[7:0] = flash_rdata_i;
              flash_d.read = 1'b1;
            end
            jtag_instruction_decode_pkg::SEL_FLASH_ADDR: dr_shift_d[15:0] = flash_q.addr;
            default: dr_shift_d[0] = 1'b0;
          endcase
        end
        jtag_instruction_decode_pkg::TAP_SHIFT_DR: begin
          // shared shifter; bits above the selected length are don't care
          dr_shift_d = {1'b0, dr_shift_q[133:1]};
          dr_shift_d[dr_len - 8'h01] = tdi_sync_q;
        end
        jtag_instruction_decode_pkg::TAP_UPDATE_DR: begin
          unique case (sel)
            jtag_instruction_decode_pkg::SEL_BOUNDARY: bsr_upd_d = dr_shift_q;
            jtag_instruction_decode_pkg::SEL_FLASH_CTRL: flash_d.ctrl = dr_shift_q[7:0];
            jtag_instruction_decode_pkg::SEL_FLASH_ADDR: flash_d.addr = dr_shift_q[15:0];
            jtag_instruction_decode_pkg::SEL_FLASH_DATA: begin
              flash_d.wdata = dr_shift_q[7:0];
              flash_d.write = 1'b1;
            end
            default: bsr_upd_d = bsr_upd_q;
          endcase
        end
        default: ir_d = ir_q;
      endcase
      if (state_d == jtag_instruction_decode_pkg::TAP_RESET) begin
        ir_d = jtag_instruction_decode_pkg::IR_RESET;
      end
    end
    // tdo changes on the falling edge so the tester samples it stable
    if (tck_fall) begin
      tdo_oe_d = 1'b0;
      if (state_q == jtag_instruction_decode_pkg::TAP_SHIFT_DR) begin
        tdo_d = dr_shift_q[0];
        tdo_oe_d = 1'b1;
      end else if (state_q == jtag_instruction_decode_pkg::TAP_SHIFT_IR) begin
        tdo_d = ir_shift_q[0];
        tdo_oe_d = 1'b1;
      end
    end
    // only extest lets boundary cells drive pins
    extest_d = (ir_d == jtag_instruction_decode_pkg::IR_EXTEST);
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= jtag_instruction_decode_pkg::TAP_RESET;
      ir_shift_q <= jtag_instruction_decode_pkg::IR_RESET;
      ir_q <= jtag_instruction_decode_pkg::IR_RESET;
      dr_shift_q <= jtag_instruction_decode_pkg::BSR_RESET;
      bsr_upd_q <= jtag_instruction_decode_pkg::BSR_RESET;
      extest_q <= 1'b1;
      flash_q <= jtag_instruction_decode_pkg::FLASH_REQ_RESET;
      tdo_q <= 1'b0;
      tdo_oe_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ir_shift_q <= ir_shift_d;
      ir_q <= ir_d;
      dr_shift_q <= dr_shift_d;
      bsr_upd_q <= bsr_upd_d;
      extest_q <= extest_d;
      flash_q <= flash_d;
      tdo_q <= tdo_d;
      tdo_oe_q <= tdo_oe_d;
    end
  end

  assign tdo_o = tdo_q;
  assign tdo_oe_o = tdo_oe_q;
  assign bsr_update_o = bsr_upd_q;
  assign extest_o = extest_q;
  assign flash_req_o = flash_q;

  property p_ir_reset;
    @(posedge core_clk_i) disable iff (reset_i)
    state_q == jtag_instruction_decode_pkg::TAP_RESET |-> ir_q == 16'h0000;
  endproperty
  a_ir_reset: assert property (p_ir_reset) else $error("ir not zero in reset state");
  property p_ir_capture;
    @(posedge core_clk_i) disable iff (reset_i)
    tck_rise && state_q == jtag_instruction_decode_pkg::TAP_CAPTURE_IR |=> ir_shift_q == 16'h0001;
  endproperty
  a_ir_capture: assert property (p_ir_capture) else $error("ir capture pattern wrong");
  property p_ir_update;
    @(posedge core_clk_i) disable iff (reset_i)
    tck_rise && state_q == jtag_instruction_decode_pkg::TAP_UPDATE_IR |=> ir_q == $past(ir_shift_q);
  endproperty
  a_ir_update: assert property (p_ir_update) else $error("ir not loaded on update");
  property p_tms_reset;
    @(posedge core_clk_i) disable iff (reset_i)
    tck_rise && tms_sync_q && state_q == jtag_instruction_decode_pkg::TAP_SELECT_IR
      |=> state_q == jtag_instruction_decode_pkg::TAP_RESET;
  endproperty
  a_tms_reset: assert property (p_tms_reset) else $error("tap missed reset state");
  property p_tdo_enable;
    @(posedge core_clk_i) disable iff (reset_i)
    tck_fall |=> tdo_oe_o == ($past(state_q) == jtag_instruction_decode_pkg::TAP_SHIFT_DR ||
                              $past(state_q) == jtag_instruction_decode_pkg::TAP_SHIFT_IR);
  endproperty
  a_tdo_enable: assert property (p_tdo_enable) else $error("tdo enable outside shift");
  property p_idcode;
    @(posedge core_clk_i) disable iff (reset_i)
    tck_rise && state_q == jtag_instruction_decode_pkg::TAP_CAPTURE_DR &&
      ir_q == 16'h0004 |=> dr_shift_q[31:0] == 32'h1000_0A01;
  endproperty
  a_idcode: assert property (p_idcode) else $error("identity value not captured");
  property p_unknown_bypass;
    @(posedge core_clk_i) disable iff (reset_i)
    !(ir_q inside {16'h0000, 16'h0002, 16'h0004, 16'h0082, 16'h0083, 16'h0084})
      |-> sel == jtag_instruction_decode_pkg::SEL_BYPASS && dr_len == 8'h01;
  endproperty
  a_unknown_bypass: assert property (p_unknown_bypass) else $error("undefined code not bypass");
  property p_bsr_update;
    @(posedge core_clk_i) disable iff (reset_i)
    tck_rise && state_q == jtag_instruction_decode_pkg::TAP_UPDATE_DR && ir_q == 16'h0002
      |=> bsr_update_o == $past(dr_shift_q) && !extest_o;
  endproperty
  a_bsr_update: assert property (p_bsr_update) else $error("preload wrong or pins driven");
  property p_flash_write;
    @(posedge core_clk_i) disable iff (reset_i)
    tck_rise && state_q == jtag_instruction_decode_pkg::TAP_UPDATE_DR && ir_q == 16'h0083
      |=> flash_req_o.write && flash_req_o.wdata == $past(dr_shift_q[7:0]) ##1 !flash_req_o.write;
  endproperty
  a_flash_write: assert property (p_flash_write) else $error("flash write strobe wrong");

endmodule

// ### pkg/jtag_instruction_decode_pkg.sv
// constants, types and carriers of the jtag instruction decode block
package jtag_instruction_decode_pkg;

  // instruction register
  localparam int IR_W = 16;
  localparam logic [15:0] IR_RESET = 16'h0000;
  localparam logic [15:0] IR_CAPTURE = 16'h0001;
  localparam logic [15:0] IR_EXTEST = 16'h0000;
  localparam logic [15:0] IR_SAMPLE = 16'h0002;
  localparam logic [15:0] IR_IDCODE = 16'h0004;
  localparam logic [15:0] IR_BYPASS = 16'hFFFF;
  localparam logic [15:0] IR_FLASH_CTRL = 16'h0082;
  localparam logic [15:0] IR_FLASH_DATA = 16'h0083;
  localparam logic [15:0] IR_FLASH_ADDR = 16'h0084;

  // data register widths
  localparam int BSR_LEN = 134;
  localparam int IDCODE_W = 32;
  localparam int FLASH_CTRL_W = 8;
  localparam int FLASH_DATA_W = 8;
  localparam int FLASH_ADDR_W = 16;
  localparam int DR_LEN_W = 8;
  localparam logic [7:0] LEN_BSR = 8'h86;
  localparam logic [7:0] LEN_BYPASS = 8'h01;
  localparam logic [7:0] LEN_IDCODE = 8'h20;
  localparam logic [7:0] LEN_FLASH_CTRL = 8'h08;
  localparam logic [7:0] LEN_FLASH_DATA = 8'h08;
  localparam logic [7:0] LEN_FLASH_ADDR = 8'h10;

  // value is arbitrary; bit 0 must stay 1
  localparam logic [31:0] IDCODE_VALUE = 32'h1000_0A01;

  typedef enum logic [3:0] {
    TAP_EXIT2_DR = 4'h0,
    TAP_EXIT1_DR = 4'h1,
    TAP_SHIFT_DR = 4'h2,
    TAP_PAUSE_DR = 4'h3,
    TAP_SELECT_IR = 4'h4,
    TAP_UPDATE_DR = 4'h5,
    TAP_CAPTURE_DR = 4'h6,
    TAP_SELECT_DR = 4'h7,
    TAP_EXIT2_IR = 4'h8,
    TAP_EXIT1_IR = 4'h9,
    TAP_SHIFT_IR = 4'hA,
    TAP_PAUSE_IR = 4'hB,
    TAP_IDLE = 4'hC,
    TAP_UPDATE_IR = 4'hD,
    TAP_CAPTURE_IR = 4'hE,
    TAP_RESET = 4'hF
  } tap_state_t;

  typedef enum logic [2:0] {
    SEL_BOUNDARY = 3'h0,
    SEL_BYPASS = 3'h1,
    SEL_IDCODE = 3'h2,
    SEL_FLASH_CTRL = 3'h3,
    SEL_FLASH_DATA = 3'h4,
    SEL_FLASH_ADDR = 3'h5
  } dr_sel_t;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic write;
    logic read;
  } flash_req_t;

  localparam flash_req_t FLASH_REQ_RESET = '0;
  localparam logic [133:0] BSR_RESET = '0;

endpackage

// ### tb/jtag_tester_model.sv
// tester model that drives the three input pins of the test port
`timescale 1ns/10ps
module jtag_tester_model (
  // clock
  input wire logic core_clk_i,
  // test port pins
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  input wire logic tdo_i,
  input wire logic tdo_oe_i
);
  int oe_miss = 0;

  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
  end

  // one tck period is 32 core cycles, far above the sync latency
  task automatic step(input logic m, input logic d, output logic so);
    @(posedge core_clk_i);
    tck_o <= 1'b0;
    tms_o <= m;
    tdi_o <= d;
    repeat (16) @(posedge core_clk_i);
    so = tdo_i;
    tck_o <= 1'b1;
    repeat (15) @(posedge core_clk_i);
  endtask

  // tck stands low between frames
  task automatic park();
    @(posedge core_clk_i);
    tck_o <= 1'b0;
  endtask

  // five ones reach reset from every state but the two pause states, then one zero parks in idle
  task automatic reset_tap();
    logic so;
    repeat (5) step(1'b1, 1'b0, so);
    step(1'b0, 1'b0, so);
    park();
  endtask

  // from idle: capture, shift len bits lsb first, update, back to idle
  task automatic scan(input logic ir, input int len, input logic [133:0] din,
                      output logic [133:0] dout);
    logic so;
    dout = '0;
    step(1'b1, 1'b0, so);
    if (ir) step(1'b1, 1'b0, so);
    step(1'b0, 1'b0, so);
    step(1'b0, 1'b0, so);
    for (int i = 0; i < len; i++) begin
      step(i == len - 1, din[i], so);
      dout[i] = so;
      if (tdo_oe_i !== 1'b1) oe_miss++;
    end
    step(1'b1, 1'b0, so);
    step(1'b0, 1'b0, so);
    park();
  endtask
endmodule

// ### tb/tb_top.sv
// self-checking bench for the jtag instruction decode block
`timescale 1ns/10ps
module tb_top;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic tck, tms, tdi, tdo, tdo_oe, extest;
  logic [133:0] bsr_cap = '0;
  logic [133:0] bsr_upd;
  logic [133:0] dout;
  logic [7:0] fl_status = 8'h00;
  logic [7:0] fl_rdata = 8'h00;
  jtag_instruction_decode_pkg::flash_req_t fl_req;
  int err_total = 0;
  int tests_run = 0;
  int rd_seen = 0;
  int wr_seen = 0;
  localparam logic [133:0] PAT_A = {6'h15, 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210};
  localparam logic [133:0] PAT_B = {6'h2E, 128'hF0E1_D2C3_B4A5_9687_7869_5A4B_3C2D_1E0F};

  always #2.5 core_clk = ~core_clk;

  jtag_instruction_decode dut (
    .core_clk_i(core_clk), .reset_i(reset), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
    .tdo_o(tdo), .tdo_oe_o(tdo_oe), .bsr_capture_i(bsr_cap), .bsr_update_o(bsr_upd),
    .extest_o(extest), .flash_status_i(fl_status), .flash_rdata_i(fl_rdata),
    .flash_req_o(fl_req)
  );

  jtag_tester_model tester (
    .core_clk_i(core_clk), .tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo),
    .tdo_oe_i(tdo_oe)
  );

  // pulse counters, one count per core cycle high
  always @(posedge core_clk) begin
    if (fl_req.read === 1'b1) rd_seen++;
    if (fl_req.write === 1'b1) wr_seen++;
  end

  task automatic check(input logic [133:0] seen, input logic [133:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s got %0h want %0h", $time, what, seen, exp);
    end
  endtask

  task automatic load_ir(input logic [15:0] code);
    logic [133:0] cap;
    tester.scan(1'b1, 16, 134'(code), cap);
    check(134'(cap[15:0]), 134'(16'h0001), "ir capture");
  endtask

  task automatic t_reset_state();
    check(134'(extest), 134'(1'b1), "extest after reset");
    check(bsr_upd, '0, "boundary update after reset");
    check(134'(tdo_oe), 134'(1'b0), "tdo idle drive");
    $display("test reset_state done");
  endtask

  task automatic t_bypass();
    logic [15:0] codes [3] = '{jtag_instruction_decode_pkg::IR_BYPASS, 16'h1234, 16'h0081};
    foreach (codes[i]) begin
      load_ir(codes[i]);
      check(134'(extest), 134'(1'b0), "extest off");
      tester.scan(1'b0, 8, 134'(8'hA5), dout);
      check(134'(dout[7:0]), 134'(8'h4A), "one stage path");
    end
    $display("test bypass done");
  endtask

  task automatic t_idcode();
    load_ir(jtag_instruction_decode_pkg::IR_IDCODE);
    tester.scan(1'b0, 32, '0, dout);
    check(134'(dout[31:0]), 134'(jtag_instruction_decode_pkg::IDCODE_VALUE), "identity");
    $display("test idcode done");
  endtask

  task automatic t_boundary();
    @(posedge core_clk);
    bsr_cap <= PAT_B;
    load_ir(jtag_instruction_decode_pkg::IR_SAMPLE);
    check(134'(extest), 134'(1'b0), "sample drives no pins");
    tester.scan(1'b0, 134, PAT_A, dout);
    check(dout, PAT_B, "sample capture");
    check(bsr_upd, PAT_A, "sample preset");
    load_ir(jtag_instruction_decode_pkg::IR_EXTEST);
    check(134'(extest), 134'(1'b1), "extest drives pins");
    tester.scan(1'b0, 134, PAT_B, dout);
    check(dout, PAT_B, "extest capture");
    check(bsr_upd, PAT_B, "extest update");
    $display("test boundary done");
  endtask

  task automatic t_flash();
    @(posedge core_clk);
    fl_status <= 8'h3C;
    fl_rdata <= 8'hC3;
    load_ir(jtag_instruction_decode_pkg::IR_FLASH_CTRL);
    tester.scan(1'b0, 8, 134'(8'h5A), dout);
    check(134'(dout[7:0]), 134'(8'h3C), "control capture");
    check(134'(fl_req.ctrl), 134'(8'h5A), "control update");
    load_ir(jtag_instruction_decode_pkg::IR_FLASH_ADDR);
    tester.scan(1'b0, 16, 134'(16'hBEEF), dout);
    tester.scan(1'b0, 16, 134'(16'h0123), dout);
    check(134'(dout[15:0]), 134'(16'hBEEF), "address capture");
    check(134'(fl_req.addr), 134'(16'h0123), "address update");
    rd_seen = 0;
    wr_seen = 0;
    load_ir(jtag_instruction_decode_pkg::IR_FLASH_DATA);
    tester.scan(1'b0, 8, 134'(8'h96), dout);
    check(134'(dout[7:0]), 134'(8'hC3), "read data");
    check(134'(rd_seen), 134'(1), "read pulses");
    check(134'(wr_seen), 134'(1), "write pulses");
    check(134'(fl_req.wdata), 134'(8'h96), "write data");
    $display("test flash done");
  endtask

  task automatic t_resets();
    load_ir(jtag_instruction_decode_pkg::IR_IDCODE);
    tester.reset_tap();
    check(134'(extest), 134'(1'b1), "ir cleared by mode select");
    load_ir(jtag_instruction_decode_pkg::IR_IDCODE);
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    repeat (4) @(posedge core_clk);
    check(134'(extest), 134'(1'b1), "ir cleared by reset");
    tester.reset_tap();
    check(134'(tester.oe_miss), 134'(0), "tdo driven while shifting");
    $display("test resets done");
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    repeat (4) @(posedge core_clk);
    tester.reset_tap();
    t_reset_state();
    t_bypass();
    t_idcode();
    t_boundary();
    t_flash();
    t_resets();
    give_verdict();
  end

  // runs take near 110 us; a hang is cut well after that
  initial begin
    #400000;
    err_total++;
    give_verdict();
  end
endmodule
